// >>> design/button_conditioner.sv
// Button synchroniser, debouncer and hold-time measurement
`timescale 1ns/1ps
module button_conditioner #(
    parameter longint PRESS_CYC = pwr_seq_pkg::PRESS_CYC,
    parameter longint FORCE_CYC = pwr_seq_pkg::FORCE_CYC
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic buttonRaw,
    output logic pressValid,
    output logic forceOff
);
    localparam int W = pwr_seq_pkg::HOLD_W;
    localparam logic [W-1:0] DEB_MAX = W'(pwr_seq_pkg::DEBOUNCE_CYC);
    localparam logic [W-1:0] PRESS_MAX = W'(PRESS_CYC);
    localparam logic [W-1:0] FORCE_MAX = W'(FORCE_CYC);

    ////////////////////////////////////////////////////////////////////////
    // State and next values
    logic sync1_ff, sync2_ff; // Two-stage synchroniser
    logic stable_ff, nxt_stable; // Debounced level
    logic [W-1:0] debCnt_ff, nxt_debCnt; // Settle counter
    logic [W-1:0] holdCnt_ff, nxt_holdCnt; // Hold counter
    logic forced_ff, nxt_forced; // Forced-off already issued
    logic pressValid_ff, nxt_pressValid;
    logic forceOff_ff, nxt_forceOff;

    // Synchroniser; first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= buttonRaw;
            sync2_ff <= sync1_ff;
        end
    end

    // Debounce, then time the hold on the always-on clock
    always_comb begin
        nxt_stable = stable_ff;
        nxt_debCnt = '0;
        nxt_holdCnt = holdCnt_ff;
        nxt_forced = forced_ff;
        nxt_pressValid = 1'b0;
        nxt_forceOff = 1'b0;
        // Level must hold steady before it is believed [R11]
        if (sync2_ff != stable_ff) begin
            nxt_debCnt = debCnt_ff + W'(1);
            if (debCnt_ff >= DEB_MAX) begin
                nxt_stable = sync2_ff;
                nxt_debCnt = '0;
            end
        end
        if (stable_ff) begin
            // Saturate so a very long hold does not wrap
            if (holdCnt_ff != '1) begin
                nxt_holdCnt = holdCnt_ff + W'(1);
            end
            // Past four seconds: force mechanical-off once [R3] [R11]
            if (holdCnt_ff == FORCE_MAX && !forced_ff) begin
                nxt_forceOff = 1'b1;
                nxt_forced = 1'b1;
            end
        end else begin
            // Release: a press counts only if held long enough [R2] [R11]
            if (holdCnt_ff >= PRESS_MAX && !forced_ff) begin
                nxt_pressValid = 1'b1;
            end
            nxt_holdCnt = '0;
            nxt_forced = 1'b0;
        end
    end

    // Register stage
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            stable_ff <= 1'b0;
            debCnt_ff <= '0;
            holdCnt_ff <= '0;
            forced_ff <= 1'b0;
            pressValid_ff <= 1'b0;
            forceOff_ff <= 1'b0;
        end else begin
            stable_ff <= nxt_stable;
            debCnt_ff <= nxt_debCnt;
            holdCnt_ff <= nxt_holdCnt;
            forced_ff <= nxt_forced;
            pressValid_ff <= nxt_pressValid;
            forceOff_ff <= nxt_forceOff;
        end
    end

    assign pressValid = pressValid_ff;
    assign forceOff = forceOff_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_short_press_ignored: assert property (@(posedge sys_clk) disable iff (!resetn) // [R2]
        pressValid |-> $past(holdCnt_ff) >= PRESS_MAX)
        else $error("press accepted before minimum hold");
    a_force_at_limit: assert property (@(posedge sys_clk) disable iff (!resetn) // [R3]
        forceOff |-> $past(holdCnt_ff) == FORCE_MAX && $past(stable_ff))
        else $error("forced off at wrong hold count");
    a_no_press_after_force: assert property (@(posedge sys_clk) disable iff (!resetn) // [R3]
        forceOff |-> !pressValid[*2])
        else $error("press reported after forced off");
endmodule

// >>> design/power_button_state_control.sv
// Power state sequencer with button timing, status LEDs and thermal control
// What this block does
// R1: Valid press: on/suspend to soft-off, off to on
// R2: Press counts only if held half second
// R3: Hold beyond four seconds forces mechanical-off
// R4: Power-up always starts and reaches full-on
// R5: Soft-off keeps only real-time clock powered
// R6: Software selects press target from full-on
// R7: Green LED lit unless mechanical-off
// R8: Blue LED follows GPIO, default shows active
// R9: Orange blinks on activity, green on gigabit
// R10: Heat throttles clock; overtemperature requests shutdown
// R11: Debounced button timed on always-on clock
`timescale 1ns/1ps
module power_button_state_control #(
    parameter longint PRESS_CYC = pwr_seq_pkg::PRESS_CYC,
    parameter longint FORCE_CYC = pwr_seq_pkg::FORCE_CYC,
    parameter longint BLINK_CYC = pwr_seq_pkg::BLINK_CYC
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic buttonRaw, // Push button, high while held
    input wire logic supplyPresent, // Main supply good
    input wire logic [1:0] pressTarget, // Software target from full-on
    input wire logic suspendRamReq, // Processor enters suspend-to-RAM
    input wire logic suspendDiskReq, // Processor enters suspend-to-disk
    input wire logic wakeReq, // Processor wake event from suspend
    input wire logic ledGpioOverride, // Software owns blue LED
    input wire logic ledGpioValue, // Software blue LED value
    input wire logic throttleTemp, // Processor temperature high
    input wire logic overTemp, // Processor temperature critical
    input wire logic [pwr_seq_pkg::ETH_PORTS-1:0] ethLink,
    input wire logic [pwr_seq_pkg::ETH_PORTS-1:0] ethActivity,
    input wire logic [pwr_seq_pkg::ETH_PORTS-1:0] gigabitLinkIn,
    output logic mainRailEn, // Main rails on
    output logic memRailEn, // Memory kept up in suspend-to-RAM
    output logic rtcRailEn, // Real-time clock domain
    output logic osShutdownReq, // Ask OS to shut down
    output logic clockThrottle, // Lower processor clock
    output logic supply_indicator_led,
    output logic system_activity_led,
    output logic [pwr_seq_pkg::ETH_PORTS-1:0] ethActivityLed,
    output logic [pwr_seq_pkg::ETH_PORTS-1:0] gigabit_link_up,
    output logic [2:0] powerState // Current state code
);
    localparam int W = pwr_seq_pkg::HOLD_W;
    // Last count of the blink divider before it wraps
    localparam logic [W-1:0] BLINK_MAX = W'(BLINK_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // Button events from the conditioner
    logic pressValid; // One-cycle pulse: accepted press, on release
    logic forceOff; // One-cycle pulse: hold crossed the force limit

    // Synchronise, debounce and time the button [R2] [R11]
    button_conditioner #(
        .PRESS_CYC(PRESS_CYC),
        .FORCE_CYC(FORCE_CYC)
    ) button_conditioner_inst (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .buttonRaw(buttonRaw),
        .pressValid(pressValid),
        .forceOff(forceOff)
    );

    ////////////////////////////////////////////////////////////////////////
    // Power state machine
    pwr_seq_pkg::pwr_state_e state_ff, nxt_state; // Current power state
    logic supplyPrev_ff, nxt_supplyPrev; // Supply level one cycle ago

    // Next state: supply loss first, then supply return, then the forced hold, then presses
    always_comb begin
        nxt_state = state_ff;
        nxt_supplyPrev = supplyPresent;
        if (!supplyPresent) begin
            // Supply gone: all rails and the green LED go dark
            nxt_state = pwr_seq_pkg::ST_MECH_OFF; // [R4] [R7]
        end else if (!supplyPrev_ff) begin
            // Supply back: always start, no stored choice is consulted
            nxt_state = pwr_seq_pkg::ST_FULL_ON; // [R4]
        end else if (forceOff) begin
            // Long hold wins over configuration and processor state
            nxt_state = pwr_seq_pkg::ST_MECH_OFF; // [R3]
        end else if (pressValid) begin
            case (state_ff)
                pwr_seq_pkg::ST_FULL_ON: begin
                    // Software picks where a press from full-on leads [R1] [R6]
                    if (pressTarget == pwr_seq_pkg::TGT_SUSP_RAM) begin
                        nxt_state = pwr_seq_pkg::ST_SUSP_RAM;
                    end else if (pressTarget == pwr_seq_pkg::TGT_SUSP_DISK) begin
                        nxt_state = pwr_seq_pkg::ST_SUSP_DISK;
                    end else begin
                        // Unused codes fall back to soft-off
                        nxt_state = pwr_seq_pkg::ST_SOFT_OFF;
                    end
                end
                pwr_seq_pkg::ST_SUSP_RAM, pwr_seq_pkg::ST_SUSP_DISK: begin
                    // Suspended system goes fully off [R1]
                    nxt_state = pwr_seq_pkg::ST_SOFT_OFF;
                end
                pwr_seq_pkg::ST_SOFT_OFF, pwr_seq_pkg::ST_MECH_OFF: begin
                    // Off system comes back on [R1]
                    nxt_state = pwr_seq_pkg::ST_FULL_ON;
                end
                default: begin
                    // Unreachable code: recover to full-on
                    nxt_state = pwr_seq_pkg::ST_FULL_ON;
                end
            endcase
        end else begin
            // Processor-driven moves when the button is quiet
            case (state_ff)
                pwr_seq_pkg::ST_FULL_ON: begin
                    if (suspendRamReq) begin
                        nxt_state = pwr_seq_pkg::ST_SUSP_RAM;
                    end else if (suspendDiskReq) begin
                        nxt_state = pwr_seq_pkg::ST_SUSP_DISK;
                    end
                end
                pwr_seq_pkg::ST_SUSP_RAM, pwr_seq_pkg::ST_SUSP_DISK: begin
                    if (wakeReq) begin
                        nxt_state = pwr_seq_pkg::ST_FULL_ON;
                    end
                end
                default: begin
                    // Off states wait for a press or supply return
                    nxt_state = state_ff;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rail enables and status LEDs, decoded from the next state and the supply level
    logic mainRail_ff, nxt_mainRail; // Main rails
    logic memRail_ff, nxt_memRail; // Memory rail
    logic rtcRail_ff, nxt_rtcRail; // Real-time clock rail
    logic pwrLed_ff, nxt_pwrLed; // Green supply indicator
    logic sysLed_ff, nxt_sysLed; // Blue activity indicator
    logic throttle_ff, nxt_throttle; // Clock throttle request
    logic shutdown_ff, nxt_shutdown; // Shutdown request to the OS
    logic nxtActive; // Next state counts as an active system

    // Outputs follow the state they will stand beside, so no cycle lags
    always_comb begin
        nxtActive = (nxt_state == pwr_seq_pkg::ST_FULL_ON)
            || (nxt_state == pwr_seq_pkg::ST_SUSP_RAM)
            || (nxt_state == pwr_seq_pkg::ST_SUSP_DISK);
        nxt_mainRail = (nxt_state == pwr_seq_pkg::ST_FULL_ON);
        // Memory keeps its content through suspend-to-RAM
        nxt_memRail = (nxt_state == pwr_seq_pkg::ST_FULL_ON)
            || (nxt_state == pwr_seq_pkg::ST_SUSP_RAM);
        // Only the clock domain stays up in soft-off [R5]
        nxt_rtcRail = supplyPresent;
        // Lit with supply, dark in mechanical-off [R7]
        nxt_pwrLed = supplyPresent && (nxt_state != pwr_seq_pkg::ST_MECH_OFF);
        // Software may own the blue LED; default shows activity [R8]
        if (ledGpioOverride) begin
            nxt_sysLed = ledGpioValue;
        end else begin
            nxt_sysLed = nxtActive;
        end
        // Thermal actions only matter while the processor runs [R10]
        nxt_throttle = throttleTemp && (nxt_state == pwr_seq_pkg::ST_FULL_ON);
        nxt_shutdown = overTemp && (nxt_state == pwr_seq_pkg::ST_FULL_ON);
    end

    // Register the state and every decoded output
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            // Reset lands in full-on: the unit starts by itself [R4]
            state_ff <= pwr_seq_pkg::ST_FULL_ON;
            // Held high so reset is not mistaken for a supply return
            supplyPrev_ff <= 1'b1;
            mainRail_ff <= 1'b1;
            memRail_ff <= 1'b1;
            rtcRail_ff <= 1'b1;
            pwrLed_ff <= 1'b1;
            sysLed_ff <= 1'b1;
            throttle_ff <= 1'b0;
            shutdown_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            supplyPrev_ff <= nxt_supplyPrev;
            mainRail_ff <= nxt_mainRail;
            memRail_ff <= nxt_memRail;
            rtcRail_ff <= nxt_rtcRail;
            pwrLed_ff <= nxt_pwrLed;
            sysLed_ff <= nxt_sysLed;
            throttle_ff <= nxt_throttle;
            shutdown_ff <= nxt_shutdown;
        end
    end

    assign powerState = state_ff;
    assign mainRailEn = mainRail_ff;
    assign memRailEn = memRail_ff;
    assign rtcRailEn = rtcRail_ff;
    assign supply_indicator_led = pwrLed_ff;
    assign system_activity_led = sysLed_ff;
    assign clockThrottle = throttle_ff;
    assign osShutdownReq = shutdown_ff;

    ////////////////////////////////////////////////////////////////////////
    // Blink divider for the activity LEDs
    logic [W-1:0] blinkCnt_ff, nxt_blinkCnt; // Divider count
    logic blinkPhase_ff, nxt_blinkPhase; // LED phase, flips per tick
    logic blinkTick; // One-cycle enable at the end of each half period

    assign blinkTick = (blinkCnt_ff >= BLINK_MAX);

    // Free-running, so both ports blink in step
    always_comb begin
        nxt_blinkCnt = blinkCnt_ff + W'(1);
        nxt_blinkPhase = blinkPhase_ff;
        if (blinkTick) begin
            nxt_blinkCnt = '0;
            nxt_blinkPhase = !blinkPhase_ff;
        end
    end

    // Divider registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            blinkCnt_ff <= '0;
            blinkPhase_ff <= 1'b0;
        end else begin
            blinkCnt_ff <= nxt_blinkCnt;
            blinkPhase_ff <= nxt_blinkPhase;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-port Ethernet LEDs
    for (genvar p = 0; p < pwr_seq_pkg::ETH_PORTS; p++) begin : g_port
        logic actLed_ff, nxt_actLed; // Orange activity LED
        logic gigLed_ff, nxt_gigLed; // Green gigabit LED

        // Blink only with link and activity together [R9]
        always_comb begin
            nxt_actLed = ethLink[p] && ethActivity[p] && blinkPhase_ff;
            nxt_gigLed = gigabitLinkIn[p];
        end

        // LED registers
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                actLed_ff <= 1'b0;
                gigLed_ff <= 1'b0;
            end else begin
                actLed_ff <= nxt_actLed;
                gigLed_ff <= nxt_gigLed; // [R9]
            end
        end

        assign ethActivityLed[p] = actLed_ff;
        assign gigabit_link_up[p] = gigLed_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Accepted press while off, with supply steady
    sequence s_press_while_off;
        pressValid && !forceOff && supplyPresent && supplyPrev_ff
            && (state_ff == pwr_seq_pkg::ST_SOFT_OFF || state_ff == pwr_seq_pkg::ST_MECH_OFF);
    endsequence
    // Fully on with main rails up
    sequence s_full_on;
        (state_ff == pwr_seq_pkg::ST_FULL_ON) && mainRailEn;
    endsequence

    a_press_powers_on: assert property (@(posedge sys_clk) disable iff (!resetn) // [R1]
        s_press_while_off |=> s_full_on)
        else $error("press while off did not reach full-on");
    a_force_to_mech: assert property (@(posedge sys_clk) disable iff (!resetn) // [R3]
        forceOff |=> state_ff == pwr_seq_pkg::ST_MECH_OFF)
        else $error("long hold did not reach mechanical-off");
    a_soft_off_rails: assert property (@(posedge sys_clk) disable iff (!resetn) // [R5]
        state_ff == pwr_seq_pkg::ST_SOFT_OFF |-> !mainRailEn && !memRailEn && rtcRailEn)
        else $error("wrong rails in soft-off");
    a_supply_led_dark: assert property (@(posedge sys_clk) disable iff (!resetn) // [R7]
        supply_indicator_led |-> state_ff != pwr_seq_pkg::ST_MECH_OFF)
        else $error("supply LED lit in mechanical-off");
    a_shutdown_on_heat: assert property (@(posedge sys_clk) disable iff (!resetn) // [R10]
        osShutdownReq |-> $past(overTemp) && state_ff == pwr_seq_pkg::ST_FULL_ON)
        else $error("shutdown request without overtemperature");
endmodule

// >>> design/pwr_seq_pkg.sv
// Package with states and timing constants for the power button sequencer
package pwr_seq_pkg;
    // Clock rate in Hz
    localparam longint CLK_HZ = 250_000_000;
    // Least hold time for a press, in ms
    localparam longint PRESS_MS = 500;
    // Hold time that forces mechanical-off, in ms
    localparam longint FORCE_MS = 4000;
    // Debounce settle time, in us
    localparam longint DEBOUNCE_US = 10;
    // Activity LED blink half period, in ms
    localparam longint BLINK_MS = 50;
    // Derived cycle counts (least times round up)
    localparam longint PRESS_CYC = (PRESS_MS * CLK_HZ + 999) / 1000;
    localparam longint FORCE_CYC = (FORCE_MS * CLK_HZ) / 1000 + 1;
    localparam longint DEBOUNCE_CYC = (DEBOUNCE_US * CLK_HZ + 999_999) / 1_000_000;
    localparam longint BLINK_CYC = (BLINK_MS * CLK_HZ) / 1000;
    // Counter width for hold timing
    localparam int HOLD_W = 32;
    // Number of Ethernet ports
    localparam int ETH_PORTS = 2;
    // Target choice codes for a press from full-on
    localparam logic [1:0] TGT_SOFT_OFF = 2'h0;
    localparam logic [1:0] TGT_SUSP_RAM = 2'h1;
    localparam logic [1:0] TGT_SUSP_DISK = 2'h2;
    // Power states
    typedef enum logic [2:0] {
        ST_FULL_ON,
        ST_SUSP_RAM,
        ST_SUSP_DISK,
        ST_SOFT_OFF,
        ST_MECH_OFF
    } pwr_state_e;
endpackage

// >>> testbench/pm_partner.sv
// Push button stand-in on the far side of the sequencer
`timescale 1ns/1ps
module pm_partner (
    input wire logic sys_clk,
    output logic buttonRaw
);
    // Button released at start
    initial buttonRaw = 1'b0;
    // Hold for n cycles; edges land on falling clock
    task automatic press(input int n);
        @(negedge sys_clk) buttonRaw = 1'b1;
        repeat (n) @(negedge sys_clk);
        buttonRaw = 1'b0;
    endtask
endmodule

// >>> testbench/tb_power_button_state_control.sv
// Bench for the power button sequencer
`timescale 1ns/1ps
module tb_power_button_state_control;
    logic sys_clk = 1'b0; // 250 MHz
    logic resetn = 1'b0;
    logic btn;
    logic [1:0] tgt = 2'h0;
    logic ovr = 1'b0, gVal = 1'b0, thr = 1'b0, hot = 1'b0, sup = 1'b1;
    logic sRam = 1'b0, sDisk = 1'b0, wake = 1'b0; // Processor requests
    logic [1:0] seenOn, seenOff; // Activity LED levels seen per port
    int rnd; // Raw random word
    logic [1:0] link = 2'h0, act = 2'h0, gig = 2'h0, actLed, gigLed;
    logic mainEn, rtcEn, shut, thrOut, pwrLed, sysLed;
    logic [2:0] st;
    int n_errors = 0, tests_run = 0, seed = 73587, exp;
    always #2 sys_clk = ~sys_clk;
    pm_partner pm_partner_inst (.sys_clk(sys_clk), .buttonRaw(btn));
    // Short press and force counts keep the run brief
    power_button_state_control #(.PRESS_CYC(100), .FORCE_CYC(4000), .BLINK_CYC(8))
    power_button_state_control_inst (.sys_clk(sys_clk), .resetn(resetn), .buttonRaw(btn),
        .supplyPresent(sup), .pressTarget(tgt), .suspendRamReq(sRam), .suspendDiskReq(sDisk),
        .wakeReq(wake), .ledGpioOverride(ovr), .ledGpioValue(gVal), .throttleTemp(thr),
        .overTemp(hot), .ethLink(link), .ethActivity(act), .gigabitLinkIn(gig),
        .mainRailEn(mainEn), .memRailEn(), .rtcRailEn(rtcEn), .osShutdownReq(shut),
        .clockThrottle(thrOut), .supply_indicator_led(pwrLed), .system_activity_led(sysLed),
        .ethActivityLed(actLed), .gigabit_link_up(gigLed), .powerState(st));
    ////////////////////////////////////////////////////////////////////////////////
    // Count one comparison, report a mismatch
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        tests_run++;
        if (got !== want) begin
            n_errors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, want);
        end
    endtask
    // Bounded wait for the model state, then compare
    task automatic waitSt();
        // Release is only believed after the debounce time, so allow for it
        for (int i = 0; i < 4000 && st !== exp[2:0]; i++) @(negedge sys_clk);
        chk(st, exp);
        if (st !== exp[2:0]) end_of_test();
    endtask
    // Model: next state after an accepted press
    function automatic int nextSt(int cur);
        if (cur == pwr_seq_pkg::ST_FULL_ON) begin
            if (tgt == pwr_seq_pkg::TGT_SUSP_RAM) return pwr_seq_pkg::ST_SUSP_RAM;
            if (tgt == pwr_seq_pkg::TGT_SUSP_DISK) return pwr_seq_pkg::ST_SUSP_DISK;
            return pwr_seq_pkg::ST_SOFT_OFF;
        end
        if (cur == pwr_seq_pkg::ST_SOFT_OFF || cur == pwr_seq_pkg::ST_MECH_OFF)
            return pwr_seq_pkg::ST_FULL_ON;
        return pwr_seq_pkg::ST_SOFT_OFF;
    endfunction
    // Press; at 2000 cycles or fewer it must be ignored
    task automatic doPress(input int n);
        pm_partner_inst.press(n);
        if (n > 2000) exp = nextSt(exp);
        repeat (300) @(negedge sys_clk);
        waitSt();
    endtask
    // Verdict and end of run
    task automatic end_of_test();
        $display("errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(negedge sys_clk);
        resetn = 1'b1;
        exp = pwr_seq_pkg::ST_FULL_ON;
        waitSt();
        chk({pwrLed, sysLed, mainEn, thrOut, shut}, 8'h1C);
        // Every software target from full-on, then back on
        for (int t = 0; t < 3; t++) begin
            tgt = t[1:0];
            doPress(3000);
            if (t > 0) doPress(3000);
            chk({mainEn, rtcEn, sysLed}, 8'h02);
            doPress(40);
            doPress(3000);
        end
        // Long hold forces mechanical-off, then a press restarts
        pm_partner_inst.press(8000);
        exp = pwr_seq_pkg::ST_MECH_OFF;
        waitSt();
        chk(pwrLed, 8'h00);
        // Let the forced release settle before the next press
        repeat (3000) @(negedge sys_clk);
        doPress(3000);
        // Processor suspends, then wakes
        sRam = 1'b1;
        @(negedge sys_clk);
        sRam = 1'b0;
        exp = pwr_seq_pkg::ST_SUSP_RAM;
        waitSt();
        wake = 1'b1;
        @(negedge sys_clk);
        wake = 1'b0;
        exp = pwr_seq_pkg::ST_FULL_ON;
        waitSt();
        // Supply lost, then restored: always starts on
        sup = 1'b0;
        exp = pwr_seq_pkg::ST_MECH_OFF;
        waitSt();
        repeat (2) @(negedge sys_clk);
        chk(pwrLed, 8'h00);
        sup = 1'b1;
        exp = pwr_seq_pkg::ST_FULL_ON;
        waitSt();
        repeat (2) @(negedge sys_clk);
        chk(pwrLed, 8'h01);
        // Software takes the blue LED
        ovr = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk(sysLed, 8'h00);
        // Random link states on both ports
        repeat (8) begin
            rnd = $random(seed);
            {link, act, gig} = rnd[5:0];
            seenOn = 2'h0;
            seenOff = 2'h0;
            for (int i = 0; i < 20; i++) begin
                @(negedge sys_clk);
                if (i > 1) begin
                    seenOn = seenOn | actLed;
                    seenOff = seenOff | ~actLed;
                end
            end
            chk(gigLed, gig);
            chk(actLed & ~(link & act), 8'h00);
            chk(seenOn & seenOff, link & act);
        end
        {thr, hot} = 2'h3;
        repeat (20) @(negedge sys_clk);
        chk({thrOut, shut}, 8'h03);
        end_of_test();
    end
endmodule
